// ===== twmsq_far.sv
`timescale 1ns/1ps
// ==========================================================
// Far-side target: acks its own address and every data byte
module twmsq_far #(
  parameter logic [6:0] ADDR = 7'h2A
) (
  input  wire logic scl,       // Bus clock level
  input  wire logic sda,       // Bus data level
  output logic      sda_low,   // Pulls data low
  output logic      stop_seen  // Stop since last start
);
  logic [7:0] sh;
  int         cnt;
  logic       act;
  logic       first;
  // Idle at time zero, line released to its pull-up
  initial begin
    {sda_low, stop_seen, act, first, sh} = '0;
    cnt = 0;
  end
  // Start and stop conditions
  always @(negedge sda) if (scl) begin
    {act, first, stop_seen} = 3'b110;
    cnt = 0;
  end
  always @(posedge sda) if (scl) begin
    {act, stop_seen} = 2'b01;
  end
  // Shift one bit per clock rise
  always @(posedge scl) if (act) begin
    sh = {sh[6:0], sda};
    cnt = cnt + 1;
  end
  // Ack window after the eighth bit, release after the ninth
  always @(negedge scl) if (act) begin
    if (cnt == 8) begin
      sda_low = !first || sh[7:1] == ADDR;
      act = sda_low;
      first = 1'b0;
    end else if (cnt == 9) begin
      sda_low = 1'b0;
      cnt = 0;
    end
  end
endmodule : twmsq_far

// ===== twmsq_pkg.sv
// ==========================================================
// Constants for the two-wire master/slave block
package twmsq_pkg;

  // ==========================================================
  // Clock and bus timing
  localparam int CLK_HZ      = 100_000_000;
  localparam int CLK_NS      = 10;
  localparam int BUS_HZ      = 100_000;
  localparam int HALF_CYC    = CLK_HZ / (2 * BUS_HZ);
  localparam int STRETCH_NS  = 2000;
  localparam int STRETCH_CYC = (STRETCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int TMR_W       = 16;

  // ==========================================================
  // Register offsets
  localparam int          AXI_AW   = 8;
  localparam logic [7:0]  OFS_CTRL = 8'h00;
  localparam logic [7:0]  OFS_MCMD = 8'h04;
  localparam logic [7:0]  OFS_MTXD = 8'h08;
  localparam logic [7:0]  OFS_SCFG = 8'h0C;
  localparam logic [7:0]  OFS_SRXD = 8'h10;
  localparam logic [7:0]  OFS_STAT = 8'h14;
  localparam logic [7:0]  OFS_SCLR = 8'h18;
  localparam logic [7:0]  OFS_IEN  = 8'h1C;

  // ==========================================================
  // Control bits
  localparam int CTRL_START  = 0;
  localparam int CTRL_MDIS   = 1;
  localparam int CTRL_SHARED = 2;
  localparam int CTRL_DEEP   = 3;
  localparam int CTRL_SEN    = 4;

  // ==========================================================
  // Status bits and reset value
  localparam int         ST_IDLE   = 0;
  localparam int         ST_MNAK   = 1;
  localparam int         ST_ALERT  = 2;
  localparam int         ST_AMATCH = 3;
  localparam int         ST_SNAK   = 4;
  localparam int         ST_BTF    = 5;
  localparam int         ST_RXRDY  = 6;
  localparam int         ST_W      = 7;
  localparam logic [6:0] ST_RESET  = 7'h05;

  // ==========================================================
  // Bus answers and states
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {M_IDLE, M_START, M_BIT, M_STOP} twmsq_mst_e;
  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_AACK, S_STRETCH, S_RX, S_RACK, S_TX, S_TACK
  } twmsq_slv_e;

endpackage : twmsq_pkg

// ===== twmsq_sync.sv
`timescale 1ns/1ps
// ==========================================================
// Two-flop synchroniser, one pair per bit
module twmsq_sync #(
  parameter int         W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         aclk,     // Clock
  input  wire logic         aresetn,  // Sync reset, low
  input  wire logic [W-1:0] d,        // Async inputs
  output logic      [W-1:0] q         // Synchronised
);

  logic [W-1:0] meta;

  // Per-bit flop pair
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        meta[i] <= RST[i];
        q[i]    <= RST[i];
      end else begin
        meta[i] <= d[i];
        q[i]    <= meta[i];
      end
    end
  end

endmodule : twmsq_sync

// ===== twmsq_top.sv
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// - Master raises idle at once on a NAK with bytes still pending.
// - Master still sends a stop after such an aborted transfer.
// - Master disable releases both pins at once, dropping any stop.
// - The alert input is recognised when the pin is high.
// - With shared pins the master alert input is unusable.
// - Deep sleep right after a start makes the slave NAK its address.
// - The alert flag reads set after reset until software clears it.
// - Clearing slave NAK before ack end makes the slave keep sending.
// - Address-match stretch also holds data low when receiving.
// - When receiving, stretch ends releasing data and clock in the same cycle.
module twmsq_top #(
  parameter int HALF_CYC    = twmsq_pkg::HALF_CYC,
  parameter int STRETCH_CYC = twmsq_pkg::STRETCH_CYC
) (
  input  wire logic        aclk,     // 100 MHz clock
  input  wire logic        aresetn,  // Sync reset, low
  input  wire logic [7:0]  awaddr,   // Write address
  input  wire logic        awvalid,  // Write address valid
  output logic             awready,  // Write address ready
  input  wire logic [31:0] wdata,    // Write data
  input  wire logic [3:0]  wstrb,    // Byte strobes
  input  wire logic        wvalid,   // Write data valid
  output logic             wready,   // Write data ready
  output logic [1:0]       bresp,    // Write response
  output logic             bvalid,   // Write response valid
  input  wire logic        bready,   // Write response ready
  input  wire logic [7:0]  araddr,   // Read address
  input  wire logic        arvalid,  // Read address valid
  output logic             arready,  // Read address ready
  output logic [31:0]      rdata,    // Read data
  output logic [1:0]       rresp,    // Read response
  output logic             rvalid,   // Read data valid
  input  wire logic        rready,   // Read data ready
  input  wire logic        scl_i,    // Bus clock pin level
  output logic             scl_o,    // Bus clock drive value
  output logic             scl_oe,   // Bus clock pulled low
  input  wire logic        sda_i,    // Bus data pin level
  output logic             sda_o,    // Bus data drive value
  output logic             sda_oe,   // Bus data pulled low
  input  wire logic        alert_i,  // Alert input pin
  output logic             irq       // Interrupt, high
);

  // ==========================================================
  // Pin synchronisers and edge events
  logic [2:0] pins_s;
  logic scl_s, sda_s, alert_s, scl_d, sda_d;
  logic rise, fall, start_c, stop_c;

  twmsq_sync #(.W(3), .RST(3'h3)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({alert_i, sda_i, scl_i}),
    .q       (pins_s)
  );
  assign {alert_s, sda_s, scl_s} = pins_s;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // Bus edges and start/stop
  assign rise    = scl_s & ~scl_d;
  assign fall    = ~scl_s & scl_d;
  assign start_c = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_c  = scl_s & scl_d & ~sda_d & sda_s;

  // ==========================================================
  // Register state
  logic [4:0] ctrl, next_ctrl;
  logic [6:0] m_addr, next_m_addr, s_addr, next_s_addr;
  logic [7:0] m_nb, next_m_nb, m_txd, next_m_txd, s_txd, next_s_txd;
  logic [6:1] st, next_st;
  logic [6:0] ien, next_ien;
  logic       aw_ok, next_aw_ok, w_ok, next_w_ok;
  logic [7:0] wa, next_wa;
  logic [31:0] wd, next_wd, next_rdata;
  logic       next_bvalid, next_rvalid, next_irq;
  logic [1:0] next_bresp, next_rresp;
  logic       start_p, next_start_p, mdis_p, next_mdis_p;
  logic [31:0] bm, rd;
  logic [6:0] stat;
  logic       m_idle, mnak_set, s_match_set, s_nak_set, s_btf_set;
  logic       s_rx_set;
  logic [7:0] s_rxd;

  assign stat = {st, m_idle};
  assign bm = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};

  // Read mux
  always_comb begin
    rd = '0;
    case (araddr)
      twmsq_pkg::OFS_CTRL: rd[4:2] = ctrl[4:2];
      twmsq_pkg::OFS_MCMD: rd[15:0] = {m_nb, 1'b0, m_addr};
      twmsq_pkg::OFS_MTXD: rd[7:0] = m_txd;
      twmsq_pkg::OFS_SCFG: rd[15:0] = {s_txd, 1'b0, s_addr};
      twmsq_pkg::OFS_SRXD: rd[7:0] = s_rxd;
      twmsq_pkg::OFS_STAT: rd[6:0] = stat;
      twmsq_pkg::OFS_IEN:  rd[6:0] = ien;
      default:             rd = '0;
    endcase
  end

  // Bus slave, decode and flags
  always_comb begin
    next_ctrl = ctrl;  next_m_addr = m_addr;  next_m_nb = m_nb;
    next_m_txd = m_txd;  next_s_addr = s_addr;  next_s_txd = s_txd;
    next_ien = ien;  next_wa = wa;  next_wd = wd;
    next_start_p = 1'b0;
    next_mdis_p = 1'b0;
    next_aw_ok = aw_ok | (awvalid & awready);
    next_w_ok  = w_ok | (wvalid & wready);
    if (awvalid & awready) next_wa = awaddr;
    if (wvalid & wready) next_wd = wdata & bm;
    next_bvalid = bvalid & ~bready;
    next_bresp  = bresp;
    next_st = st;
    if (aw_ok && w_ok && !bvalid) begin
      next_aw_ok  = 1'b0;
      next_w_ok   = 1'b0;
      next_bvalid = 1'b1;
      next_bresp  = twmsq_pkg::RESP_OKAY;
      case (wa)
        twmsq_pkg::OFS_CTRL: begin
          next_ctrl    = wd[4:0];
          next_start_p = wd[twmsq_pkg::CTRL_START];
          next_mdis_p  = wd[twmsq_pkg::CTRL_MDIS];
        end
        twmsq_pkg::OFS_MCMD: {next_m_nb, next_m_addr} = {wd[15:8], wd[6:0]};
        twmsq_pkg::OFS_MTXD: next_m_txd = wd[7:0];
        twmsq_pkg::OFS_SCFG: {next_s_txd, next_s_addr} = {wd[15:8], wd[6:0]};
        twmsq_pkg::OFS_SCLR: next_st = st & ~wd[6:1];
        twmsq_pkg::OFS_IEN:  next_ien = wd[6:0];
        default:             next_bresp = twmsq_pkg::RESP_SLVERR;
      endcase
    end
    // Set wins over clear
    if (alert_s && !ctrl[twmsq_pkg::CTRL_SHARED])
      next_st[twmsq_pkg::ST_ALERT] = 1'b1;
    if (mnak_set)    next_st[twmsq_pkg::ST_MNAK]   = 1'b1;
    if (s_match_set) next_st[twmsq_pkg::ST_AMATCH] = 1'b1;
    if (s_nak_set)   next_st[twmsq_pkg::ST_SNAK]   = 1'b1;
    if (s_btf_set)   next_st[twmsq_pkg::ST_BTF]    = 1'b1;
    if (s_rx_set)    next_st[twmsq_pkg::ST_RXRDY]  = 1'b1;
    next_rvalid = rvalid & ~rready;
    next_rdata  = rdata;
    next_rresp  = rresp;
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rdata  = rd;
      next_rresp  = (araddr > twmsq_pkg::OFS_IEN || araddr[1:0] != 2'h0 ||
                     araddr == twmsq_pkg::OFS_SCLR) ?
                    twmsq_pkg::RESP_SLVERR : twmsq_pkg::RESP_OKAY;
    end
    next_irq = |({next_st, m_idle} & ien);
  end

  // Register file flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= '0;  m_addr <= '0;  m_nb <= '0;  m_txd <= '0;
      s_addr <= '0;  s_txd <= '0;  ien <= '0;  wa <= '0;  wd <= '0;
      st <= twmsq_pkg::ST_RESET[6:1];
      aw_ok <= 1'b0;  w_ok <= 1'b0;  start_p <= 1'b0;  mdis_p <= 1'b0;
      awready <= 1'b0;  wready <= 1'b0;  bvalid <= 1'b0;  bresp <= '0;
      arready <= 1'b0;  rvalid <= 1'b0;  rdata <= '0;  rresp <= '0;
      irq <= 1'b0;
    end else begin
      ctrl <= next_ctrl;  m_addr <= next_m_addr;  m_nb <= next_m_nb;
      m_txd <= next_m_txd;  s_addr <= next_s_addr;  s_txd <= next_s_txd;
      ien <= next_ien;  wa <= next_wa;  wd <= next_wd;  st <= next_st;
      aw_ok <= next_aw_ok;  w_ok <= next_w_ok;
      start_p <= next_start_p;  mdis_p <= next_mdis_p;
      awready <= ~next_aw_ok;  wready <= ~next_w_ok;
      bvalid <= next_bvalid;  bresp <= next_bresp;
      arready <= ~next_rvalid;  rvalid <= next_rvalid;
      rdata <= next_rdata;  rresp <= next_rresp;  irq <= next_irq;
    end
  end

  // ==========================================================
  // Master unit
  typedef enum logic [1:0] {M_IDLE, M_START, M_BIT, M_STOP} twmsq_mst_e;
  twmsq_mst_e m_st, next_m_st;
  logic [twmsq_pkg::TMR_W-1:0] m_cnt, next_m_cnt;
  logic [3:0] m_bit, next_m_bit;
  logic [7:0] m_sh, next_m_sh, m_rem, next_m_rem;
  logic m_ph, next_m_ph, m_scl, next_m_scl, m_sda, next_m_sda, next_m_idle;
  logic m_end;

  assign m_end = (m_cnt == HALF_CYC[twmsq_pkg::TMR_W-1:0] - 1'b1);

  // Bit engine: low half, then high half after any stretch
  always_comb begin
    next_m_st = m_st;  next_m_cnt = m_cnt + 1'b1;  next_m_bit = m_bit;
    next_m_sh = m_sh;  next_m_rem = m_rem;  next_m_ph = m_ph;
    next_m_scl = m_scl;  next_m_sda = m_sda;  next_m_idle = m_idle;
    mnak_set = 1'b0;
    if (m_ph && !scl_s && m_st != M_START) next_m_cnt = '0;
    case (m_st)
      M_IDLE: begin
        next_m_cnt = '0;
        if (start_p) begin
          next_m_idle = 1'b0;
          next_m_sh = {m_addr, 1'b0};
          next_m_rem = m_nb;
          next_m_sda = 1'b1;
          next_m_st = M_START;
        end
      end
      M_START: if (m_end) begin
        next_m_scl = 1'b1;  next_m_cnt = '0;  next_m_bit = '0;
        next_m_ph = 1'b0;  next_m_st = M_BIT;
      end
      M_BIT: begin
        if (!m_ph && m_cnt == '0)
          next_m_sda = (m_bit < 4'h8) ? ~m_sh[7] : 1'b0;
        if (!m_ph && m_end) begin
          next_m_scl = 1'b0;  next_m_ph = 1'b1;  next_m_cnt = '0;
        end else if (m_ph && m_end) begin
          next_m_scl = 1'b1;  next_m_ph = 1'b0;  next_m_cnt = '0;
          if (m_bit < 4'h8) begin
            next_m_sh = m_sh << 1;
            next_m_bit = m_bit + 1'b1;
          end else if (sda_s) begin
            mnak_set = 1'b1;
            if (m_rem != '0) next_m_idle = 1'b1;
            next_m_st = M_STOP;
          end else if (m_rem != '0) begin
            next_m_sh = m_txd;  next_m_rem = m_rem - 1'b1;
            next_m_bit = '0;
          end else next_m_st = M_STOP;
        end
      end
      M_STOP: begin
        if (!m_ph && m_cnt == '0) next_m_sda = 1'b1;
        if (!m_ph && m_end) begin
          next_m_scl = 1'b0;  next_m_ph = 1'b1;  next_m_cnt = '0;
        end else if (m_ph && m_end) begin
          next_m_sda = 1'b0;  next_m_idle = 1'b1;  next_m_st = M_IDLE;
        end
      end
      default: next_m_st = M_IDLE;
    endcase
    if (mdis_p) begin
      next_m_st = M_IDLE;  next_m_scl = 1'b0;  next_m_sda = 1'b0;
      next_m_idle = 1'b1;  next_m_ph = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      m_st <= M_IDLE;  m_cnt <= '0;  m_bit <= '0;  m_sh <= '0;
      m_rem <= '0;  m_ph <= 1'b0;  m_scl <= 1'b0;  m_sda <= 1'b0;
      m_idle <= twmsq_pkg::ST_RESET[twmsq_pkg::ST_IDLE];
    end else begin
      m_st <= next_m_st;  m_cnt <= next_m_cnt;  m_bit <= next_m_bit;
      m_sh <= next_m_sh;  m_rem <= next_m_rem;  m_ph <= next_m_ph;
      m_scl <= next_m_scl;  m_sda <= next_m_sda;  m_idle <= next_m_idle;
    end
  end

  // ==========================================================
  // Slave unit
  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_AACK, S_STRETCH, S_RX, S_RACK, S_TX, S_TACK
  } twmsq_slv_e;
  twmsq_slv_e s_st, next_s_st;
  logic [3:0] s_cnt, next_s_cnt;
  logic [7:0] s_sh, next_s_sh, next_s_rxd;
  logic [twmsq_pkg::TMR_W-1:0] s_tmr, next_s_tmr;
  logic s_rw, next_s_rw, s_nap, next_s_nap;
  logic s_scl, next_s_scl, s_sda, next_s_sda;

  always_comb begin
    next_s_st = s_st;  next_s_cnt = s_cnt;  next_s_sh = s_sh;
    next_s_rxd = s_rxd;  next_s_tmr = s_tmr;  next_s_rw = s_rw;
    next_s_nap = s_nap;  next_s_scl = s_scl;  next_s_sda = s_sda;
    s_match_set = 1'b0;  s_nak_set = 1'b0;  s_btf_set = 1'b0;
    s_rx_set = 1'b0;
    case (s_st)
      S_IDLE: ;
      S_ADDR: begin
        if (ctrl[twmsq_pkg::CTRL_DEEP]) next_s_nap = 1'b1;
        if (rise && s_cnt < 4'h8) begin
          next_s_sh = {s_sh[6:0], sda_s};  next_s_cnt = s_cnt + 1'b1;
        end
        if (fall && s_cnt == 4'h8) begin
          if (s_sh[7:1] == s_addr && ctrl[twmsq_pkg::CTRL_SEN] &&
              !s_nap) begin
            next_s_sda = 1'b1;  next_s_rw = s_sh[0];  next_s_st = S_AACK;
          end else next_s_st = S_IDLE;
        end
      end
      S_AACK: if (fall) begin
        s_match_set = 1'b1;  next_s_scl = 1'b1;
        next_s_sda = ~s_rw;
        next_s_tmr = '0;  next_s_st = S_STRETCH;
      end
      S_STRETCH: begin
        next_s_tmr = s_tmr + 1'b1;
        if (s_tmr == STRETCH_CYC[twmsq_pkg::TMR_W-1:0] - 1'b1) begin
          next_s_scl = 1'b0;
          next_s_sda = s_rw & ~s_txd[7];
          next_s_sh = s_txd;  next_s_cnt = '0;
          next_s_st = s_rw ? S_TX : S_RX;
        end
      end
      S_RX: begin
        if (rise) begin
          next_s_sh = {s_sh[6:0], sda_s};  next_s_cnt = s_cnt + 1'b1;
        end
        if (fall && s_cnt == 4'h8) begin
          next_s_sda = 1'b1;  next_s_rxd = s_sh;  s_rx_set = 1'b1;
          next_s_st = S_RACK;
        end
      end
      S_RACK: if (fall) begin
        next_s_sda = 1'b0;  s_btf_set = 1'b1;  next_s_cnt = '0;
        next_s_st = S_RX;
      end
      S_TX: begin
        if (rise) next_s_cnt = s_cnt + 1'b1;
        if (fall) begin
          next_s_sh = s_sh << 1;
          next_s_sda = (s_cnt < 4'h8) ? ~s_sh[6] : 1'b0;
          if (s_cnt == 4'h8) next_s_st = S_TACK;
        end
      end
      S_TACK: begin
        if (rise && sda_s) s_nak_set = 1'b1;
        if (fall) begin
          s_btf_set = 1'b1;
          if (st[twmsq_pkg::ST_SNAK]) next_s_st = S_IDLE;
          else begin
            next_s_sh = s_txd;  next_s_sda = ~s_txd[7];
            next_s_cnt = '0;  next_s_st = S_TX;
          end
        end
      end
      default: next_s_st = S_IDLE;
    endcase
    if (start_c) begin
      next_s_st = S_ADDR;  next_s_cnt = '0;  next_s_nap = 1'b0;
      next_s_sda = 1'b0;
    end else if (stop_c) begin
      next_s_st = S_IDLE;  next_s_sda = 1'b0;  next_s_scl = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_st <= S_IDLE;  s_cnt <= '0;  s_sh <= '0;  s_rxd <= '0;
      s_tmr <= '0;  s_rw <= 1'b0;  s_nap <= 1'b0;
      s_scl <= 1'b0;  s_sda <= 1'b0;
    end else begin
      s_st <= next_s_st;  s_cnt <= next_s_cnt;  s_sh <= next_s_sh;
      s_rxd <= next_s_rxd;  s_tmr <= next_s_tmr;  s_rw <= next_s_rw;
      s_nap <= next_s_nap;  s_scl <= next_s_scl;  s_sda <= next_s_sda;
    end
  end

  // Pin drivers, open drain
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_oe <= 1'b0;  sda_oe <= 1'b0;  scl_o <= 1'b0;  sda_o <= 1'b0;
    end else begin
      scl_oe <= next_m_scl | next_s_scl;
      sda_oe <= next_m_sda | next_s_sda;
      scl_o  <= 1'b0;
      sda_o  <= 1'b0;
    end
  end

  // ==========================================================
  // Checks
  AST_IDLE_ON_NAK: assert property (@(posedge aclk) disable iff (!aresetn)
    (m_st == M_BIT && m_ph && m_end && m_bit == 4'h8 && sda_s &&
     m_rem != '0 && !mdis_p) |=> m_idle && m_st == M_STOP)
    else $error("idle not raised at nak");
  AST_STOP_AFTER_NAK: assert property (@(posedge aclk) disable iff (!aresetn)
    (m_st == M_BIT && m_ph && m_end && m_bit == 4'h8 && sda_s && !mdis_p)
    |=> ##1 m_sda && m_st == M_STOP)
    else $error("no stop after nak");
  AST_MDIS_RELEASE: assert property (@(posedge aclk) disable iff (!aresetn)
    mdis_p |=> !m_scl && !m_sda && m_st == M_IDLE)
    else $error("disable did not release pins");
  AST_ALERT_HIGH: assert property (@(posedge aclk) disable iff (!aresetn)
    (alert_s && !ctrl[twmsq_pkg::CTRL_SHARED])
    |=> st[twmsq_pkg::ST_ALERT])
    else $error("high alert not flagged");
  AST_ALERT_SHARED: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl[twmsq_pkg::CTRL_SHARED] && !st[twmsq_pkg::ST_ALERT])
    |=> !st[twmsq_pkg::ST_ALERT])
    else $error("alert flagged with shared pins");
  AST_NAP_NAK: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_st == S_ADDR && s_nap && fall && s_cnt == 4'h8 && !start_c)
    |=> s_st == S_IDLE && !s_sda)
    else $error("address acked after sleep");
  AST_ALERT_RESET: assert property (@(posedge aclk) disable iff (!aresetn)
    !$past(aresetn) |-> st[twmsq_pkg::ST_ALERT])
    else $error("alert flag clear after reset");
  AST_TX_GOES_ON: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_st == S_TACK && fall && !st[twmsq_pkg::ST_SNAK] && !start_c &&
     !stop_c) |=> s_st == S_TX)
    else $error("slave stopped after cleared nak");
  AST_STRETCH_SDA: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_st == S_STRETCH && !s_rw) |-> s_scl && s_sda)
    else $error("data not held during stretch");
  AST_RELEASE_TOGETHER: assert property (@(posedge aclk)
    disable iff (!aresetn)
    ($past(s_st) == S_STRETCH && s_st == S_RX) |-> !s_scl && !s_sda)
    else $error("stretch release not simultaneous");

endmodule : twmsq_top

// ===== two_wire_master_slave_quirks_tb_top.sv
`timescale 1ns/1ps
// ==========================================================
// Bench for the two-wire master/slave block
module two_wire_master_slave_quirks_tb_top;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        alert_i, tb_scl_low, tb_sda_low;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rd_d;
  logic [3:0]  wstrb;
  logic [1:0]  rd_r, wr_r;
  wire  logic  awready, wready, bvalid, arready, rvalid, irq;
  wire  logic  scl_o, scl_oe, sda_o, sda_oe, far_low, stop_seen;
  wire  logic [1:0]  bresp, rresp;
  wire  logic [31:0] rdata;
  int          n_fail, num_checks;
  // Open-drain wires with pull-ups
  wire  logic  scl_w = !(scl_oe || tb_scl_low);
  wire  logic  sda_w = !(sda_oe || far_low || tb_sda_low);

  twmsq_top #(.HALF_CYC(8), .STRETCH_CYC(40)) i_twmsq_top (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .scl_i(scl_w),
    .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe(sda_oe), .alert_i(alert_i), .irq(irq));
  twmsq_far #(.ADDR(7'h2A)) i_twmsq_far (.scl(scl_w), .sda(sda_w),
    .sda_low(far_low), .stop_seen(stop_seen));

  // 100 MHz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // ==========================================================
  // Shared helpers
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tmo(input logic ok);
    if (ok !== 1'b1) begin
      n_fail++;
      $display("[ERR] %0t ns: wait timed out", $time);
      close_out();
    end
  endtask : tmo
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    {awaddr, wdata, wstrb} <= {a, d, 4'hF};
    {awvalid, wvalid, bready} <= 3'b111;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      t++;
    end while (!bvalid && t < 60);
    tmo(bvalid);
    wr_r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int t;
    t = 0;
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      t++;
    end while (!rvalid && t < 60);
    tmo(rvalid);
    {rd_d, rd_r} = {rdata, rresp};
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd
  // One bus bit at 80 ns, data moved mid low phase
  task automatic lbit(input logic b);
    tb_scl_low <= 1'b1;
    cyc(2);
    tb_sda_low <= !b;
    cyc(2);
    tb_scl_low <= 1'b0;
    cyc(4);
  endtask : lbit
  task automatic lbyte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) lbit(b[i]);
  endtask : lbyte

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    rd(twmsq_pkg::OFS_STAT);
    chk(rd_d, 32'h5);
    chk(irq, 1'b0);
    rd(8'h40);
    chk(rd_r, twmsq_pkg::RESP_SLVERR);
    wr(twmsq_pkg::OFS_STAT, 32'h0);
    chk(wr_r, twmsq_pkg::RESP_SLVERR);
    $display("test reset done");
  endtask : t_reset
  task automatic t_alert();
    wr(twmsq_pkg::OFS_SCLR, 32'h4);
    rd(twmsq_pkg::OFS_STAT);
    chk(rd_d[twmsq_pkg::ST_ALERT], 1'b0);
    wr(twmsq_pkg::OFS_IEN, 32'h4);
    alert_i <= 1'b1;
    cyc(6);
    chk(irq, 1'b1);
    alert_i <= 1'b0;
    cyc(4);
    wr(twmsq_pkg::OFS_SCLR, 32'h4);
    cyc(2);
    chk(irq, 1'b0);
    wr(twmsq_pkg::OFS_CTRL, 32'h4);
    alert_i <= 1'b1;
    cyc(6);
    rd(twmsq_pkg::OFS_STAT);
    chk(rd_d[twmsq_pkg::ST_ALERT], 1'b0);
    alert_i <= 1'b0;
    cyc(4);
    wr(twmsq_pkg::OFS_CTRL, 32'h0);
    $display("test alert done");
  endtask : t_alert
  task automatic t_nak();
    int t;
    t = 0;
    wr(twmsq_pkg::OFS_MCMD, 32'h0000_0233);    // Two bytes, nobody answers
    wr(twmsq_pkg::OFS_CTRL, 32'h1);
    do begin
      rd(twmsq_pkg::OFS_STAT);
      t++;
    end while (!rd_d[twmsq_pkg::ST_IDLE] && t < 200);
    tmo(rd_d[twmsq_pkg::ST_IDLE]);
    chk(stop_seen, 1'b0);
    chk(rd_d[twmsq_pkg::ST_MNAK], 1'b1);
    t = 0;
    while (!stop_seen && t < 100) begin
      cyc(1);
      t++;
    end
    chk(stop_seen, 1'b1);
    wr(twmsq_pkg::OFS_SCLR, 32'h7E);
    $display("test nak done");
  endtask : t_nak
  task automatic t_slave(input logic deep);
    int t;
    logic seen;
    t = 0;
    seen = 1'b0;
    wr(twmsq_pkg::OFS_SCFG, 32'h51);
    wr(twmsq_pkg::OFS_CTRL, 32'h10);
    tb_sda_low <= 1'b1;
    cyc(4);
    if (deep) wr(twmsq_pkg::OFS_CTRL, 32'h18);
    lbyte(8'hA2);
    lbit(1'b1);
    chk(sda_w, deep);
    tb_scl_low <= 1'b1;
    cyc(4);
    tb_scl_low <= 1'b0;
    // Stretch: both lines held and freed together
    do begin
      @(posedge aclk);
      seen = seen | scl_oe;
      chk(sda_oe, scl_oe);
      t++;
    end while (!scl_w && t < 100);
    tmo(scl_w);
    chk(seen, !deep);
    lbit(1'b0);
    tb_sda_low <= 1'b0;
    cyc(4);
    wr(twmsq_pkg::OFS_CTRL, 32'h0);
    $display("test slave done");
  endtask : t_slave
  task automatic t_stx();
    int t;
    logic [7:0] got;
    t = 0;
    got = '0;
    wr(twmsq_pkg::OFS_SCFG, 32'h5A51);
    wr(twmsq_pkg::OFS_CTRL, 32'h10);
    tb_sda_low <= 1'b1;
    cyc(4);
    lbyte(8'hA3);
    lbit(1'b1);
    tb_scl_low <= 1'b1;
    cyc(4);
    tb_scl_low <= 1'b0;
    do begin
      cyc(1);
      t++;
    end while (!scl_w && t < 100);
    tmo(scl_w);
    cyc(2);
    got[7] = sda_w;
    for (int i = 6; i >= 0; i--) begin
      lbit(1'b1);
      got[i] = sda_w;
    end
    chk(got, 8'h5A);
    lbit(1'b0);
    for (int i = 7; i >= 0; i--) begin
      lbit(1'b1);
      got[i] = sda_w;
    end
    chk(got, 8'h5A);
    lbit(1'b1);
    lbit(1'b0);
    rd(twmsq_pkg::OFS_STAT);
    chk(rd_d[5:4], 2'b11);
    wr(twmsq_pkg::OFS_SCLR, 32'h30);
    tb_sda_low <= 1'b0;
    cyc(4);
    wr(twmsq_pkg::OFS_CTRL, 32'h0);
    $display("test slave transmit done");
  endtask : t_stx
  task automatic t_mdis();
    wr(twmsq_pkg::OFS_MCMD, 32'h0000_032A);    // Three bytes to far target
    wr(twmsq_pkg::OFS_CTRL, 32'h1);
    cyc(200);
    wr(twmsq_pkg::OFS_CTRL, 32'h2);
    repeat (20) begin
      chk({scl_oe, sda_oe}, 2'b00);
      cyc(1);
    end
    rd(twmsq_pkg::OFS_STAT);
    chk(rd_d[twmsq_pkg::ST_IDLE], 1'b1);
    $display("test disable done");
  endtask : t_mdis

  // Main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {alert_i, tb_scl_low, tb_sda_low} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    n_fail = 0;
    num_checks = 0;
    aresetn = 1'b0;
    cyc(6);
    aresetn <= 1'b1;
    cyc(1);
    t_reset();
    t_alert();
    t_nak();
    t_slave(1'b0);
    t_slave(1'b1);
    t_stx();
    t_mdis();
    close_out();
  end
endmodule : two_wire_master_slave_quirks_tb_top
